/* rtl/gpc_defs.vh */
// Constants for the general purpose pin configuration block
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define GPC_ADDR_CFG      12'h1E0
`define GPC_ADDR_DATA_DIR 12'h1E4
`define GPC_ADDR_IRQ      12'h1E8
`define GPC_ADDR_TU_IRQ   12'h1EC
// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define GPC_CFG_BUF_LO    0
`define GPC_CFG_EPOL8     12
`define GPC_CFG_EPOL9     13
`define GPC_CFG_OE_LO     14
`define GPC_CFG_POL_LO    16
`define GPC_CFG_TCLR_LO   28
`define GPC_CFG_WMASK     32'h3FFFFFFF
`define GPC_CFG_RESET     32'h00003000
`define GPC_HI_LO         16
`define GPC_LO12_MASK     32'h00000FFF
// ----------------------------------------
// Timing and bus codes
// ----------------------------------------
`define GPC_MIN_ACTIVE_NS 40
`define GPC_CLK_PERIOD_NS 4
`define GPC_RESP_OKAY     2'b00
`define GPC_RESP_SLVERR   2'b10
`endif

/* rtl/gpc_pin_filter.v */
// Input synchroniser with minimum active time qualification for one pin
module gpc_pin_filter #(
  parameter CNT_W = 4,
  parameter MIN_CYC = 11
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin_i,
  output reg  level_r,
  output reg  qual_r
);
  reg             s1_r;
  reg             s2_r;
  reg             s3_r;
  reg [CNT_W-1:0] cnt_r;

  // ----------------------------------------
  // Synchroniser and qualifier
  // ----------------------------------------
  // Level changes once the second and third stage agree; qual rises after MIN_CYC + 1 stable cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
      cnt_r   <= {CNT_W{1'b0}};
      qual_r  <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
      // Counter restarts on every level change so glitches never qualify
      if (level_r != s3_r || s2_r != s3_r) begin
        cnt_r  <= {CNT_W{1'b0}};
        qual_r <= 1'b0;
      end else if (cnt_r != MIN_CYC[CNT_W-1:0]) begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        qual_r <= 1'b1;
      end
    end
  end
endmodule

/* rtl/gpc_top.v */
// General purpose pin configuration block with AXI4-Lite register slave
`include "gpc_defs.vh"
module gpc_top #(
  parameter NPIN = 12
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire [11:0]     s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [11:0]     s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire [NPIN-1:0] pin_in,
  output reg  [NPIN-1:0] pin_out,
  output reg  [NPIN-1:0] pin_oe,
  input  wire            compare_event9,
  input  wire            compare_event8,
  output reg  [1:0]      capture_event,
  output reg             time_unit_irq_status_enable,
  output reg             irq
);
  localparam MIN_CYC = (`GPC_MIN_ACTIVE_NS + `GPC_CLK_PERIOD_NS - 1) / `GPC_CLK_PERIOD_NS;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [31:0]     cfg_r;
  reg [NPIN-1:0] data_r;
  reg [NPIN-1:0] pin_direction_bits_r;
  reg [NPIN-1:0] irq_sts_r;
  reg [NPIN-1:0] irq_en_r;
  reg            tu_irq_en_r;
  reg [11:0]     awaddr_r;
  reg [31:0]     wdata_r;
  reg [3:0]      wstrb_r;
  reg            aw_have_r;
  reg            w_have_r;
  reg [1:0]      act_prev_r;

  wire [NPIN-1:0] pin_irq_polarity = cfg_r[`GPC_CFG_POL_LO +: NPIN];
  wire [NPIN-1:0] pin_buffer_type  = cfg_r[`GPC_CFG_BUF_LO +: NPIN];
  wire [1:0]      event_oe         = cfg_r[`GPC_CFG_OE_LO +: 2];
  wire [1:0]      tclr_en          = cfg_r[`GPC_CFG_TCLR_LO +: 2];
  wire            pin9_event_polarity = cfg_r[`GPC_CFG_EPOL9];
  wire            pin8_event_polarity = cfg_r[`GPC_CFG_EPOL8];

  // Byte-lane merge shared by every register write
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------
  // Pin input conditioning
  // ----------------------------------------
  wire [NPIN-1:0] lvl;
  wire [NPIN-1:0] qual;
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_flt
      gpc_pin_filter #(
        .CNT_W   (4),
        .MIN_CYC (MIN_CYC)
      ) u_flt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_i   (pin_in[g]),
        .level_r (lvl[g]),
        .qual_r  (qual[g])
      );
    end
  endgenerate

  // Pin is active when its level matches its polarity and has lasted the minimum time
  wire [NPIN-1:0] pin_active = qual & ~(lvl ^ pin_irq_polarity);
  // Effective direction: pins 9 and 8 forced to output by event enables
  wire [NPIN-1:0] eff_dir = pin_direction_bits_r | {{(NPIN-10){1'b0}}, event_oe, 8'h00};
  wire [1:0] act98 = pin_active[9:8] & ~eff_dir[9:8];
  wire [1:0] act_rise = act98 & ~act_prev_r;
  wire       tu_clear = |(act_rise & tclr_en);

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  wire        aw_fire = s_axi_awvalid & s_axi_awready;
  wire        w_fire  = s_axi_wvalid & s_axi_wready;
  wire        do_wr   = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [31:0] wmerge_cfg = merge(cfg_r, wdata_r, wstrb_r);
  wire [31:0] wmerge_dd  = merge({4'h0, pin_direction_bits_r, 4'h0, data_r}, wdata_r, wstrb_r);
  wire [31:0] wmerge_irq = merge({4'h0, irq_en_r, 4'h0, 12'h000}, wdata_r, wstrb_r);
  wire [31:0] wclr_irq   = merge(32'h00000000, wdata_r, wstrb_r);
  wire        wr_cfg = do_wr & (awaddr_r == `GPC_ADDR_CFG);
  wire        wr_dd  = do_wr & (awaddr_r == `GPC_ADDR_DATA_DIR);
  wire        wr_irq = do_wr & (awaddr_r == `GPC_ADDR_IRQ);
  wire        wr_tu  = do_wr & (awaddr_r == `GPC_ADDR_TU_IRQ);
  wire        wr_hit = wr_cfg | wr_dd | wr_irq | wr_tu;

  // Address and data latch independently, so either may arrive first
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPC_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~aw_fire & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~w_fire & ~s_axi_bvalid;
      if (aw_fire) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (w_fire) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register updates and interrupt status
  // ----------------------------------------
  // Hardware set wins over a software clear landing in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r                       <= `GPC_CFG_RESET;
      data_r                      <= {NPIN{1'b0}};
      pin_direction_bits_r        <= {NPIN{1'b0}};
      irq_sts_r                   <= {NPIN{1'b0}};
      irq_en_r                    <= {NPIN{1'b0}};
      tu_irq_en_r                 <= 1'b0;
      time_unit_irq_status_enable <= 1'b0;
      act_prev_r                  <= 2'b00;
      capture_event               <= 2'b00;
      irq                         <= 1'b0;
    end else begin
      act_prev_r    <= act98;
      capture_event <= act_rise;
      if (wr_cfg)
        cfg_r <= wmerge_cfg & `GPC_CFG_WMASK;
      if (wr_dd) begin
        data_r               <= wmerge_dd[NPIN-1:0];
        pin_direction_bits_r <= wmerge_dd[`GPC_HI_LO +: NPIN];
      end
      if (wr_irq)
        irq_en_r <= wmerge_irq[`GPC_HI_LO +: NPIN];
      irq_sts_r <= (irq_sts_r & ~(wr_irq ? wclr_irq[NPIN-1:0] : {NPIN{1'b0}})) | pin_active;
      // Timer enable takes its own byte lane, so a write that leaves lane 2 out keeps the bit
      if (wr_tu & wstrb_r[`GPC_HI_LO / 8])
        tu_irq_en_r <= wdata_r[`GPC_HI_LO];
      // Timer interrupt status: compare event sets, pin edge or write-one clears
      if (compare_event9 | compare_event8)
        time_unit_irq_status_enable <= 1'b1;
      else if (tu_clear | (wr_tu & wclr_irq[0]))
        time_unit_irq_status_enable <= 1'b0;
      irq <= |(irq_sts_r & irq_en_r) | (time_unit_irq_status_enable & tu_irq_en_r);
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Event pins drive the compare event at its programmed active level
  reg [NPIN-1:0] drv_val;
  always @* begin
    drv_val = data_r;
    if (event_oe[1])
      drv_val[9] = ~(compare_event9 ^ pin9_event_polarity);
    if (event_oe[0])
      drv_val[8] = ~(compare_event8 ^ pin8_event_polarity);
  end

  // Open-drain only drives a low value; a registered output adds one cycle of lag
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe  <= {NPIN{1'b0}};
    end else begin
      pin_out <= drv_val & ~pin_buffer_type;
      pin_oe  <= eff_dir & ~(pin_buffer_type & drv_val);
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  reg [31:0] rd_val;
  reg        rd_hit;
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `GPC_ADDR_CFG:      rd_val = cfg_r & `GPC_CFG_WMASK;
      `GPC_ADDR_DATA_DIR: rd_val = {4'h0, pin_direction_bits_r, 4'h0, (eff_dir & data_r) | (~eff_dir & lvl)};
      `GPC_ADDR_IRQ:      rd_val = {4'h0, irq_en_r, 4'h0, irq_sts_r};
      `GPC_ADDR_TU_IRQ:   rd_val = {15'h0000, tu_irq_en_r, 15'h0000, time_unit_irq_status_enable};
      default:            rd_hit = 1'b0;
    endcase
  end

  // One read at a time; address accepted only while no answer is pending
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GPC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* tb/gpc_checker.sv */
// Port level checks for the pin configuration block
module gpc_checker #(
  parameter NPIN = 12
) (
  input logic            aclk,
  input logic            aresetn,
  input logic            s_axi_awvalid,
  input logic            s_axi_awready,
  input logic            s_axi_wvalid,
  input logic            s_axi_wready,
  input logic            s_axi_bvalid,
  input logic            s_axi_arvalid,
  input logic            s_axi_arready,
  input logic            s_axi_rvalid,
  input logic [NPIN-1:0] pin_in,
  input logic [NPIN-1:0] pin_out,
  input logic [NPIN-1:0] pin_oe,
  input logic            compare_event9,
  input logic [1:0]      capture_event,
  input logic            time_unit_irq_status_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wr_age_r;
  logic       wr_near;
  // Pins other than 9 and 8 may only move close to a write response
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_age_r <= 2'h3;
    else if (s_axi_bvalid) wr_age_r <= 2'h0;
    else if (wr_age_r != 2'h3) wr_age_r <= wr_age_r + 2'h1;
  end
  assign wr_near = s_axi_bvalid || wr_age_r != 2'h3;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_other_pins_quiet: assert property (
    !$stable({pin_out[11:10], pin_oe[11:10], pin_out[7:0], pin_oe[7:0]}) |-> wr_near or ##[1:2] s_axi_bvalid)
    else $error("plain pin moved without a write");
  a_pin9_cause: assert property (
    !$stable({pin_out[9], pin_oe[9]}) |-> ($past(compare_event9) != $past(compare_event9, 2) ||
      $past(compare_event9, 2) != $past(compare_event9, 3) || wr_near) or ##[1:2] s_axi_bvalid)
    else $error("pin 9 moved without event or write");
  a_capture_single: assert property (capture_event[1] |=> !capture_event[1])
    else $error("capture pulse too long");
  a_capture_qual: assert property (capture_event[1] |-> $past(pin_in[9], 5) == $past(pin_in[9], 9))
    else $error("capture on a short level");
  a_capture_input: assert property (capture_event[1] |-> !pin_oe[9])
    else $error("capture on a driven pin");
  a_timer_set: assert property (compare_event9 |-> ##[1:2] time_unit_irq_status_enable)
    else $error("compare event did not set timer status");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  c_capture: cover property (capture_event[1]);
  c_timer_clear: cover property ($fell(time_unit_irq_status_enable));
  c_pin9_drive: cover property ($rose(pin_oe[9]));
endmodule
bind gpc_top gpc_checker #(.NPIN(NPIN)) gpc_checker_i (.*);

/* tb/gpc_pin_ext.sv */
// Outside circuit on the pins: pull-ups and a switchable driver
module gpc_pin_ext #(
  parameter NPIN = 12
) (
  input  logic [NPIN-1:0] pin_out,
  input  logic [NPIN-1:0] pin_oe,
  input  logic [NPIN-1:0] ext_en,
  input  logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Device drive wins; a released line rises to the pull-up
  always_comb begin
    for (int i = 0; i < NPIN; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
  end
endmodule

/* tb/test_gpio_pin_configuration.sv */
// Self-checking bench for the pin configuration block
`include "gpc_defs.vh"
module test_gpio_pin_configuration;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic        compare_event9, compare_event8, time_unit_irq_status_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr, pin_in, pin_out, pin_oe, ext_en, ext_val;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, capture_event;
  int          n_errors, n_tests, n_cap9, base;
  gpc_top gpc_top_i (.*);
  gpc_pin_ext gpc_pin_ext_i (.*);
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  // Count pin 9 capture pulses
  always @(posedge aclk) if (capture_event[1] === 1'h1) n_cap9 <= n_cap9 + 1;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic bound(input int n);
    if (n >= 50) begin
      n_errors++;
      $display("Error at %0t: no answer", $time);
      close_out();
    end
  endtask
  // Each channel is dropped at the edge where its ready is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    bound(n);
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    bound(n);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_cfg();
    rd(`GPC_ADDR_CFG, 32'h00003000, `GPC_RESP_OKAY);
    wr(`GPC_ADDR_CFG, 32'hFFFFFFFF, `GPC_RESP_OKAY);
    rd(`GPC_ADDR_CFG, 32'h3FFFFFFF, `GPC_RESP_OKAY);
    rd(12'h1F0, 32'h0, `GPC_RESP_SLVERR);
    wr(`GPC_ADDR_CFG, 32'h00003000, `GPC_RESP_OKAY);
  endtask
  task automatic t_open_drain();
    wr(`GPC_ADDR_CFG, 32'h00003008, `GPC_RESP_OKAY);
    wr(`GPC_ADDR_DATA_DIR, 32'h000C0004, `GPC_RESP_OKAY);
    tick(2);
    chk({pin_oe[3:2], pin_out[3:2]}, 4'hD);
    wr(`GPC_ADDR_DATA_DIR, 32'h000C0008, `GPC_RESP_OKAY);
    tick(2);
    chk({pin_oe[3:2], pin_out[2]}, 3'h2);
    rd(`GPC_ADDR_DATA_DIR, 32'h000C0FFB, `GPC_RESP_OKAY);
    wr(`GPC_ADDR_DATA_DIR, 32'h0, `GPC_RESP_OKAY);
  endtask
  // Pin 9 push-pull active high, pin 8 open drain active low
  task automatic t_event();
    wr(`GPC_ADDR_CFG, 32'h0000E100, `GPC_RESP_OKAY);
    tick(3);
    chk({pin_oe[9:8], pin_out[9]}, 3'h4);
    compare_event9 <= 1'h1;
    compare_event8 <= 1'h1;
    tick(3);
    chk({pin_oe[9:8], pin_out[9:8]}, 4'hE);
    compare_event9 <= 1'h0;
    compare_event8 <= 1'h0;
    wr(`GPC_ADDR_TU_IRQ, 32'h1, `GPC_RESP_OKAY);
    tick(2);
    chk(time_unit_irq_status_enable, 1'h0);
    wr(`GPC_ADDR_CFG, 32'h00003000, `GPC_RESP_OKAY);
    tick(2);
    chk(pin_oe[9:8], 2'h0);
  endtask
  // Pin 5 high-level interrupt: short pulse, long pulse, mask, clear
  task automatic t_pin_irq();
    wr(`GPC_ADDR_CFG, 32'h00203000, `GPC_RESP_OKAY);
    ext_en[5] <= 1'h1;
    tick(20);
    wr(`GPC_ADDR_IRQ, 32'h00000FFF, `GPC_RESP_OKAY);
    rd(`GPC_ADDR_IRQ, 32'h0, `GPC_RESP_OKAY);
    wr(`GPC_ADDR_IRQ, 32'h00200000, `GPC_RESP_OKAY);
    ext_val[5] <= 1'h1;
    tick(8);
    ext_val[5] <= 1'h0;
    tick(20);
    rd(`GPC_ADDR_IRQ, 32'h00200000, `GPC_RESP_OKAY);
    ext_val[5] <= 1'h1;
    tick(16);
    ext_val[5] <= 1'h0;
    tick(20);
    chk(irq, 1'h1);
    wr(`GPC_ADDR_IRQ, 32'h00200000, `GPC_RESP_OKAY);
    rd(`GPC_ADDR_IRQ, 32'h00200020, `GPC_RESP_OKAY);
    wr(`GPC_ADDR_IRQ, 32'h0, `GPC_RESP_OKAY);
    tick(2);
    chk(irq, 1'h0);
    wr(`GPC_ADDR_IRQ, 32'h00000020, `GPC_RESP_OKAY);
    rd(`GPC_ADDR_IRQ, 32'h0, `GPC_RESP_OKAY);
    ext_val[5] <= 1'h1;
    wr(`GPC_ADDR_CFG, 32'h00003000, `GPC_RESP_OKAY);
    ext_en[5] <= 1'h0;
  endtask
  // Low-active pin 9 clears timer status only while enabled
  task automatic t_timer(input logic [31:0] cfg, input logic exp);
    wr(`GPC_ADDR_CFG, cfg, `GPC_RESP_OKAY);
    compare_event9 <= 1'h1;
    tick(1);
    compare_event9 <= 1'h0;
    base = n_cap9;
    ext_en[9] <= 1'h1;
    ext_val[9] <= 1'h0;
    tick(20);
    ext_en[9] <= 1'h0;
    tick(20);
    chk(time_unit_irq_status_enable, exp);
    chk(n_cap9 - base, 1);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {compare_event9, compare_event8, aresetn} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, ext_en, ext_val} = 48'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {n_errors, n_tests, n_cap9} = 0;
    tick(20);
    aresetn <= 1'h1;
    tick(2);
    t_cfg();
    t_open_drain();
    t_event();
    t_pin_irq();
    t_timer(32'h00003000, 1'h1);
    t_timer(32'h20003000, 1'h0);
    close_out();
  end
endmodule
